/* File: apcr_claim_flags.sv */
// Claim tag flip-flops with write-one-to-set and write-one-to-clear ports.
module apcr_claim_flags
  import apcr_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_set_wr,
  input  wire logic        i_clr_wr,
  input  wire apcr_flags_t i_bits,
  output logic [FLAG_W-1:0] o_flags
);

  // ==========================================================================
  // State
  apcr_claim_state_t s_q;
  apcr_claim_state_t s_d;
  apcr_flags_t       set_bits;
  apcr_flags_t       clr_bits;

  // Ones set or clear a tag, zeros leave it; set is applied last so it wins.
  always_comb
  begin
    s_d      = s_q;
    set_bits = i_set_wr ? (i_bits & CLAIM_IMPL_MASK) : CLAIM_RESET;
    clr_bits = i_clr_wr ? (i_bits & CLAIM_IMPL_MASK) : CLAIM_RESET;
    s_d.flags = (s_q.flags & ~clr_bits) | set_bits;
  end

  // Tags come up unclaimed.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      s_q <= '{flags: CLAIM_RESET};
    else
      s_q <= s_d;
  end

  assign o_flags = s_q.flags;

endmodule : apcr_claim_flags

/* File: apcr_claim_ident_bank.sv */
// Top of the claim tag and identification register bank.

// Behaviour
// - Bit 1 of the claim pair is the external tag, 1 means claimed.
// - Bit 0 of the claim pair is the self-hosted tag, 1 means claimed.
// - Both claim tags are implemented.
// - Claim set decodes at 0xfa0, claim clear at 0xfa4.
// - Affinity words at 0xfa8 and 0xfac read all zero.
// - Architecture word: bit 20 reads one, bits 19:16 read zero.
// - Architecture word carries fixed architect and architecture codes.
// - First capability word reads all zero.
// - Capability words at 0xfc4 and 0xfc0 read all zero.
// - Category word at 0xfcc reads zero, sub and major types zero.
// - Claim set and clear are 32-bit, readable and writable.
module apcr_claim_ident_bank
  import apcr_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire apcr_addr_t  i_addr,
  input  wire apcr_word_t  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output apcr_word_t       o_rdata,
  output logic [FLAG_W-1:0] o_claim_flags,
  output logic             o_self_sole,
  output logic             o_ext_sole,
  output logic             o_contended
);

  // ==========================================================================
  // Declarations
  apcr_main_state_t s_q;
  apcr_main_state_t s_d;
  logic             set_wr;
  logic             clr_wr;
  apcr_flags_t      flags;
  apcr_word_t       mux_word;
  logic             mux_hit;

  // ==========================================================================
  // Write decode
  // Only the two claim offsets take writes; every other write falls away.
  assign set_wr = i_wr && (i_addr == OFF_CLAIM_SET);
  assign clr_wr = i_wr && (i_addr == OFF_CLAIM_CLR);

  // ==========================================================================
  // Claim tags
  apcr_claim_flags u_flags (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_set_wr (set_wr),
    .i_clr_wr (clr_wr),
    .i_bits   (i_wdata[FLAG_W-1:0]),
    .o_flags  (flags)
  );

  // ==========================================================================
  // Read selection
  apcr_read_mux u_mux (
    .i_addr  (i_addr),
    .i_flags (flags),
    .o_word  (mux_word),
    .o_hit   (mux_hit)
  );

  // ==========================================================================
  // Next state
  // Read data live one cycle only; outside that cycle the bus sees zero.
  // Ownership status trails the tags by one cycle, which is harmless since
  // agents judge a claim from the clear view and never sample the status.
  always_comb
  begin
    s_d           = s_q;
    s_d.rdata     = i_rd ? mux_word : ZERO_WORD;
    s_d.self_sole = (flags == SELF_ONLY);
    s_d.ext_sole  = (flags == EXT_ONLY);
    s_d.contended = (flags == CLAIM_IMPL_MASK);
  end

  // Synchronous reset clears read data and status.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      s_q <= '{rdata: ZERO_WORD, self_sole: 1'b0, ext_sole: 1'b0,
               contended: 1'b0};
    else
      s_q <= s_d;
  end

  // ==========================================================================
  // Outputs
  assign o_rdata       = s_q.rdata;
  assign o_claim_flags = flags;
  assign o_self_sole   = s_q.self_sole;
  assign o_ext_sole    = s_q.ext_sole;
  assign o_contended   = s_q.contended;

  // ==========================================================================
  // Claim tag checks
  // The external tag rises in the cycle after a set write with bit 1 high.
  a_ext_tag_set: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    set_wr && i_wdata[EXT_TAG_BIT] |=> flags[EXT_TAG_BIT])
    else $error("external tag not set by claim set write");

  // The self-hosted tag rises after a set write with bit 0 high.
  a_self_tag_set: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    set_wr && i_wdata[SELF_TAG_BIT] |=> flags[SELF_TAG_BIT])
    else $error("self tag not set by claim set write");

  // A clear write with bit 1 high drops the external tag.
  a_ext_tag_clear: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    clr_wr && i_wdata[EXT_TAG_BIT] |=> !flags[EXT_TAG_BIT])
    else $error("external tag not cleared");

  // A clear write with bit 0 high drops the self-hosted tag.
  a_self_tag_clear: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    clr_wr && i_wdata[SELF_TAG_BIT] |=> !flags[SELF_TAG_BIT])
    else $error("self tag not cleared");

  // Zeros in a set write leave the other tag as it was.
  a_set_zero_hold: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    set_wr && !i_wdata[EXT_TAG_BIT]
      |=> flags[EXT_TAG_BIT] == $past(flags[EXT_TAG_BIT]))
    else $error("set write with zero changed a tag");

  // Zeros in a clear write leave the other tag as it was.
  a_clr_zero_hold: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    clr_wr && !i_wdata[SELF_TAG_BIT]
      |=> flags[SELF_TAG_BIT] == $past(flags[SELF_TAG_BIT]))
    else $error("clear write with zero changed a tag");

  // Both tags can stand set together, so both are implemented.
  a_both_tags: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    set_wr && (i_wdata[FLAG_W-1:0] == CLAIM_IMPL_MASK)
      |=> flags == CLAIM_IMPL_MASK)
    else $error("both claim tags not held");

  // Tags move only on a claim write.
  a_tags_quiet: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !set_wr && !clr_wr |=> $stable(flags))
    else $error("claim tags changed without a claim write");

  // Writes to fixed words never disturb the tags.
  a_ro_write_ignored: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_wr && is_ro_addr(i_addr) |=> $stable(flags))
    else $error("write to a read-only word changed state");

  // Tags leave reset unclaimed.
  a_reset_unclaimed: assert property (
    @(posedge i_mclk)
    i_rst |=> flags == CLAIM_RESET)
    else $error("claim tags not clear after reset");

  // ==========================================================================
  // Read-back checks
  // The set view answers the implemented mask.
  a_set_read_mask: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && (i_addr == OFF_CLAIM_SET)
      |=> o_rdata == {{(DATA_W-FLAG_W){1'b0}}, CLAIM_IMPL_MASK})
    else $error("claim set read is not the implemented mask");

  // The clear view answers the tags as they stood at the read.
  a_clr_read_tags: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && (i_addr == OFF_CLAIM_CLR)
      |=> o_rdata == {{(DATA_W-FLAG_W){1'b0}}, $past(flags)})
    else $error("claim clear read does not show the tags");

  // A set followed at once by a read of the clear view shows the new tag.
  a_set_then_read: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    set_wr && i_wdata[EXT_TAG_BIT]
      ##1 (i_rd && (i_addr == OFF_CLAIM_CLR))
      |=> o_rdata[EXT_TAG_BIT])
    else $error("claimed external tag not visible on read");

  // Affinity words read as zero.
  a_aff_read_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && (i_addr == OFF_AFF0 || i_addr == OFF_AFF1)
      |=> o_rdata == ZERO_WORD)
    else $error("affinity word not zero");

  // Architecture word shows presence and revision zero.
  a_arch_presence: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && (i_addr == OFF_ARCH)
      |=> o_rdata[ARCH_PRESENT_BIT]
          && o_rdata[ARCH_REV_LSB +: NIB_W] == ARCH_REV)
    else $error("architecture presence or revision wrong");

  // Architecture word shows the fixed codes.
  a_arch_codes: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && (i_addr == OFF_ARCH)
      |=> o_rdata[DATA_W-1:ARCH_CODE_LSB] == ARCH_CODE
          && o_rdata[ARCH_REV_LSB-1:0] == ARCH_ID)
    else $error("architecture codes wrong");

  // First capability word reads as zero.
  a_cap0_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && (i_addr == OFF_CAP0) |=> o_rdata == ZERO_WORD)
    else $error("first capability word not zero");

  // Further capability words read as zero.
  a_cap_more_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && (i_addr == OFF_CAP1 || i_addr == OFF_CAP2)
      |=> o_rdata == ZERO_WORD)
    else $error("further capability word not zero");

  // Category word shows zero types and zero upper bits.
  a_cat_fields: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && (i_addr == OFF_CAT)
      |=> o_rdata[CAT_SUB_LSB +: NIB_W] == CAT_SUB
          && o_rdata[NIB_W-1:0] == CAT_MAJOR
          && o_rdata[DATA_W-1:CAT_SUB_LSB+NIB_W] == '0)
    else $error("category word wrong");

  // Data stand for exactly one cycle after a read.
  a_rdata_one_cycle: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !i_rd |=> o_rdata == ZERO_WORD)
    else $error("read data present without a read");

  // Unmapped reads answer zero.
  a_unmapped_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && !mux_hit |=> o_rdata == ZERO_WORD)
    else $error("unmapped read returned data");

  // ==========================================================================
  // Ownership status checks
  // A lone self tag shows as sole ownership one cycle later.
  a_self_sole: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    flags == SELF_ONLY |=> o_self_sole && !o_ext_sole && !o_contended)
    else $error("self ownership status wrong");

  // A lone external tag shows as sole ownership one cycle later.
  a_ext_sole: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    flags == EXT_ONLY |=> o_ext_sole && !o_self_sole && !o_contended)
    else $error("external ownership status wrong");

  // Both tags set flags contention and no owner.
  a_contended: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    flags == CLAIM_IMPL_MASK
      |=> o_contended && !o_self_sole && !o_ext_sole)
    else $error("contention status wrong");

  // No tag set means no owner and no contention.
  a_unclaimed_idle: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    flags == CLAIM_RESET
      |=> !o_contended && !o_self_sole && !o_ext_sole)
    else $error("status shows owner while unclaimed");

  // ==========================================================================
  // Further tag and reset checks
  // Zeros in a set write leave the self-hosted tag as it was.
  a_set_keeps_self: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    set_wr && !i_wdata[SELF_TAG_BIT]
      |=> flags[SELF_TAG_BIT] == $past(flags[SELF_TAG_BIT]))
    else $error("set write with zero changed the self tag");

  // Zeros in a clear write leave the external tag as it was.
  a_clr_keeps_ext: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    clr_wr && !i_wdata[EXT_TAG_BIT]
      |=> flags[EXT_TAG_BIT] == $past(flags[EXT_TAG_BIT]))
    else $error("clear write with zero changed the external tag");

  // A set write can only add tags, never take one away.
  a_set_only_adds: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    set_wr |=> (flags & $past(flags)) == $past(flags))
    else $error("set write dropped a tag");

  // A clear write can only take tags away, never add one.
  a_clr_only_drops: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    clr_wr |=> (flags & ~$past(flags)) == CLAIM_RESET)
    else $error("clear write raised a tag");

  // Clearing with both bits high leaves the port unclaimed.
  a_clr_all: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    clr_wr && (i_wdata[FLAG_W-1:0] == CLAIM_IMPL_MASK)
      |=> flags == CLAIM_RESET)
    else $error("clear of both tags left a tag set");

  // Writes outside the two claim offsets, mapped or not, leave the tags.
  a_other_wr_ignored: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_wr && (i_addr != OFF_CLAIM_SET) && (i_addr != OFF_CLAIM_CLR)
      |=> $stable(flags))
    else $error("write outside the claim offsets changed the tags");

  // A read never disturbs the tags, so polling the clear view is safe.
  a_read_keeps_tags: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd |=> $stable(flags))
    else $error("read changed the claim tags");

  // Both claim views read zero above the implemented tags, so software
  // that probes for more tags finds only two.
  a_claim_upper_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_rd && (i_addr == OFF_CLAIM_SET || i_addr == OFF_CLAIM_CLR)
      |=> o_rdata[DATA_W-1:FLAG_W] == '0)
    else $error("claim view shows bits above the implemented tags");

  // At most one ownership status stands at any time.
  a_status_onehot: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    $onehot0({o_self_sole, o_ext_sole, o_contended}))
    else $error("more than one ownership status set");

  // Reset empties the read data and every status output.
  a_reset_outputs: assert property (
    @(posedge i_mclk)
    i_rst |=> o_rdata == ZERO_WORD && !o_self_sole && !o_ext_sole
              && !o_contended)
    else $error("read data or status not clear after reset");

endmodule : apcr_claim_ident_bank

/* File: apcr_dbg_agent.sv */
// Debugger-side bus agent that reaches the claim and ident bank.
module apcr_dbg_agent
  import apcr_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire apcr_word_t i_rdata,
  output apcr_addr_t      o_addr,
  output apcr_word_t      o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  timeunit 1ns;
  timeprecision 100ps;

  // Unknown-port architecture code; the value is arbitrary.
  localparam logic [15:0] UNKNOWN_PORT_ID = 16'hc0de;
  localparam apcr_addr_t  PORT_IDENT_OFF  = 12'h0fc;

  // ==========================================================================
  // Bus cycles
  // Idle values from time zero so no bank input floats.
  initial
  begin
    o_addr  = 12'h000;
    o_wdata = 32'h0000_0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // One write; an idle edge comes first so one task never reassigns a strobe.
  task automatic wr(input apcr_addr_t a, input apcr_word_t d);
    @(posedge i_mclk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_mclk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
    #1;
  endtask : wr

  // One read; the data stand only in the cycle after the read edge.
  task automatic rd(input apcr_addr_t a, output apcr_word_t d);
    @(posedge i_mclk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_mclk);
    o_rd   <= 1'b0;
    #1;
    d = i_rdata;
  endtask : rd

  // A write followed by a read with no gap between the strobes.
  task automatic wr_rd(input apcr_addr_t a, input apcr_word_t d,
                       input apcr_addr_t ra, output apcr_word_t q);
    @(posedge i_mclk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_mclk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b1;
    o_addr  <= ra;
    o_wdata <= ~d;
    @(posedge i_mclk);
    o_rd    <= 1'b0;
    #1;
    q = i_rdata;
  endtask : wr_rd

  // ==========================================================================
  // Claim protocol
  // Set own tag, then look for the rival; back off if it is also set.
  task automatic claim(input int b, output logic got);
    apcr_word_t v;
    wr(OFF_CLAIM_SET, 32'h1 << b);
    rd(OFF_CLAIM_CLR, v);
    got = (v[1-b] === 1'b0);
    if (!got)
      wr(OFF_CLAIM_CLR, 32'h1 << b);
  endtask : claim

  // Reads the architecture word; an unknown-port code sends the debugger on
  // to the port identification register for the details.
  task automatic probe_arch(output apcr_word_t arch, output logic more);
    apcr_word_t idw;
    rd(OFF_ARCH, arch);
    more = (arch[ARCH_REV_LSB-1:0] === UNKNOWN_PORT_ID);
    if (more)
      rd(PORT_IDENT_OFF, idw);
  endtask : probe_arch

  // Drop own tag once the port is no longer needed.
  task automatic release_tag(input int b);
    wr(OFF_CLAIM_CLR, 32'h1 << b);
  endtask : release_tag

endmodule : apcr_dbg_agent

/* File: apcr_pkg.sv */
// Constants, types and decode helpers shared by the claim and ident bank.
package apcr_pkg;

  // ==========================================================================
  // Widths and types
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 2;
  localparam int NIB_W  = 4;

  typedef logic [ADDR_W-1:0] apcr_addr_t;
  typedef logic [DATA_W-1:0] apcr_word_t;
  typedef logic [FLAG_W-1:0] apcr_flags_t;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam apcr_addr_t OFF_CLAIM_SET = 12'hfa0;
  localparam apcr_addr_t OFF_CLAIM_CLR = 12'hfa4;
  localparam apcr_addr_t OFF_AFF0      = 12'hfa8;
  localparam apcr_addr_t OFF_AFF1      = 12'hfac;
  localparam apcr_addr_t OFF_ARCH      = 12'hfbc;
  localparam apcr_addr_t OFF_CAP2      = 12'hfc0;
  localparam apcr_addr_t OFF_CAP1      = 12'hfc4;
  localparam apcr_addr_t OFF_CAP0      = 12'hfc8;
  localparam apcr_addr_t OFF_CAT       = 12'hfcc;

  // ==========================================================================
  // Field positions and values
  localparam int SELF_TAG_BIT     = 0;
  localparam int EXT_TAG_BIT      = 1;
  localparam int ARCH_CODE_LSB    = 21;
  localparam int ARCH_PRESENT_BIT = 20;
  localparam int ARCH_REV_LSB     = 16;
  localparam int CAT_SUB_LSB      = 4;

  // Architect and architecture codes: the values are arbitrary.
  localparam logic [10:0] ARCH_CODE    = 11'h2a5;
  localparam logic [15:0] ARCH_ID      = 16'h5a01;
  localparam logic        ARCH_PRESENT = 1'h1;
  localparam logic [3:0]  ARCH_REV     = 4'h0;
  localparam logic [3:0]  CAT_SUB      = 4'h0;
  localparam logic [3:0]  CAT_MAJOR    = 4'h0;

  localparam apcr_flags_t CLAIM_RESET     = 2'h0;
  localparam apcr_flags_t CLAIM_IMPL_MASK = 2'h3;
  localparam apcr_flags_t SELF_ONLY       = 2'h1;
  localparam apcr_flags_t EXT_ONLY        = 2'h2;
  localparam apcr_word_t  ZERO_WORD       = 32'h0000_0000;
  localparam apcr_word_t  ARCH_WORD       =
    {ARCH_CODE, ARCH_PRESENT, ARCH_REV, ARCH_ID};
  localparam apcr_word_t  CAT_WORD        = {24'h00_0000, CAT_SUB, CAT_MAJOR};

  // ==========================================================================
  // State records
  typedef struct packed {
    apcr_flags_t flags;
  } apcr_claim_state_t;

  typedef struct packed {
    apcr_word_t rdata;
    logic       self_sole;
    logic       ext_sole;
    logic       contended;
  } apcr_main_state_t;

  // True for the fixed read-only words of the bank.
  function automatic logic is_ro_addr(apcr_addr_t a);
    return a inside {OFF_AFF0, OFF_AFF1, OFF_ARCH, OFF_CAP0, OFF_CAP1,
                     OFF_CAP2, OFF_CAT};
  endfunction : is_ro_addr

endpackage : apcr_pkg

/* File: apcr_read_mux.sv */
// Read-back selection of the claim view and the fixed identity words.
module apcr_read_mux
  import apcr_pkg::*;
(
  input  wire apcr_addr_t  i_addr,
  input  wire apcr_flags_t i_flags,
  output apcr_word_t       o_word,
  output logic             o_hit
);

  // ==========================================================================
  // Decode
  // Pads the tag vector into a full word with zeros above.
  function automatic apcr_word_t widen(apcr_flags_t f);
    return {{(DATA_W-FLAG_W){1'b0}}, f};
  endfunction : widen

  // Unmapped addresses answer zero so software never sees stale data.
  always_comb
  begin
    o_word = ZERO_WORD;
    o_hit  = 1'b1;
    unique case (i_addr)
      OFF_CLAIM_SET: o_word = widen(CLAIM_IMPL_MASK);
      OFF_CLAIM_CLR: o_word = widen(i_flags);
      OFF_AFF0:      o_word = ZERO_WORD;
      OFF_AFF1:      o_word = ZERO_WORD;
      OFF_ARCH:      o_word = ARCH_WORD;
      OFF_CAP0:      o_word = ZERO_WORD;
      OFF_CAP1:      o_word = ZERO_WORD;
      OFF_CAP2:      o_word = ZERO_WORD;
      OFF_CAT:       o_word = CAT_WORD;
      default:       o_hit  = 1'b0;
    endcase
  end

endmodule : apcr_read_mux

/* File: tb.sv */
// Self-checking bench for the claim tag and identification bank.
module tb;
  import apcr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic              i_mclk = 1'b0;
  logic              i_rst  = 1'b1;
  apcr_addr_t        addr;
  apcr_word_t        wdata;
  apcr_word_t        rdata;
  logic              wr;
  logic              rd;
  logic [FLAG_W-1:0] flags;
  logic              self_sole;
  logic              ext_sole;
  logic              contended;
  int                n_errors        = 0;
  int                samples_checked = 0;
  int                cycles          = 0;

  // ==========================================================================
  // Clock, parts and watchdog
  always #5 i_mclk = ~i_mclk;

  apcr_claim_ident_bank apcr_claim_ident_bank_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_claim_flags(flags),
    .o_self_sole(self_sole), .o_ext_sole(ext_sole),
    .o_contended(contended)
  );

  apcr_dbg_agent apcr_dbg_agent_inst (
    .i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd)
  );

  // A hang is cut short well past the 125 or so cycles the tests need.
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic check(input apcr_word_t seen, input apcr_word_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Tags now, then the one-cycle-late ownership status.
  task automatic tags(input apcr_flags_t f);
    logic [2:0] st;
    check(32'(flags), 32'(f));
    @(posedge i_mclk);
    #1;
    st = {f === 2'h3, f === 2'h2, f === 2'h1};
    check(32'({contended, ext_sole, self_sole}), 32'(st));
  endtask : tags

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Scenarios
  // Fixed words read as expected and shrug off writes of all ones.
  task automatic test_map();
    apcr_addr_t a [9] = '{OFF_AFF0, OFF_AFF1, OFF_ARCH, OFF_CAP2, OFF_CAP1,
                          OFF_CAP0, OFF_CAT, 12'hfb0, 12'h000};
    apcr_word_t e [9] = '{32'h0, 32'h0, {ARCH_CODE, 1'b1, 4'h0, ARCH_ID},
                          32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    apcr_word_t v;
    logic       m;
    apcr_dbg_agent_inst.probe_arch(v, m);
    check(v, e[2]);
    check(32'(m), 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      apcr_dbg_agent_inst.rd(a[i], v);
      check(v, e[i]);
      apcr_dbg_agent_inst.wr(a[i], 32'hffff_ffff);
      apcr_dbg_agent_inst.rd(a[i], v);
      check(v, e[i]);
    end
    apcr_dbg_agent_inst.rd(OFF_CLAIM_SET, v);
    check(v, 32'h0000_0003);
    tags(2'h0);
  endtask : test_map

  // Set and clear each tag, with zero bits and upper bits left alone.
  task automatic test_set_clear();
    apcr_word_t v;
    apcr_dbg_agent_inst.wr(OFF_CLAIM_SET, 32'h0000_0002);
    tags(2'h2);
    apcr_dbg_agent_inst.wr(OFF_CLAIM_SET, 32'hffff_fffc);
    tags(2'h2);
    apcr_dbg_agent_inst.wr(OFF_CLAIM_CLR, 32'h0000_0001);
    tags(2'h2);
    apcr_dbg_agent_inst.wr(OFF_CLAIM_SET, 32'h0000_0001);
    tags(2'h3);
    apcr_dbg_agent_inst.rd(OFF_CLAIM_CLR, v);
    check(v, 32'h0000_0003);
    apcr_dbg_agent_inst.rd(OFF_CLAIM_SET, v);
    check(v, 32'h0000_0003);
    apcr_dbg_agent_inst.wr(OFF_CLAIM_CLR, 32'h0000_0002);
    tags(2'h1);
    apcr_dbg_agent_inst.wr(OFF_CLAIM_CLR, 32'h0000_0000);
    tags(2'h1);
    apcr_dbg_agent_inst.wr(OFF_CLAIM_CLR, 32'hffff_ffff);
    tags(2'h0);
  endtask : test_set_clear

  // A read right behind a write already sees the new tags.
  task automatic test_b2b();
    apcr_word_t q;
    apcr_dbg_agent_inst.wr_rd(OFF_CLAIM_SET, 32'h3, OFF_CLAIM_CLR, q);
    check(q, 32'h0000_0003);
    apcr_dbg_agent_inst.wr_rd(OFF_CLAIM_CLR, 32'h3, OFF_CLAIM_CLR, q);
    check(q, 32'h0000_0000);
    tags(2'h0);
  endtask : test_b2b

  // Two agents race for the port; the late one must see the rival.
  task automatic test_race();
    logic g;
    apcr_dbg_agent_inst.claim(0, g);
    check(32'(g), 32'h1);
    apcr_dbg_agent_inst.claim(1, g);
    check(32'(g), 32'h0);
    tags(2'h1);
    apcr_dbg_agent_inst.release_tag(0);
    tags(2'h0);
    apcr_dbg_agent_inst.claim(1, g);
    check(32'(g), 32'h1);
    tags(2'h2);
    apcr_dbg_agent_inst.release_tag(1);
    tags(2'h0);
  endtask : test_race

  // Reset in mid-run drops both tags, and the clear view then reads zero.
  task automatic test_reset();
    apcr_word_t v;
    apcr_dbg_agent_inst.wr(OFF_CLAIM_SET, 32'h0000_0003);
    tags(2'h3);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    tags(2'h0);
    apcr_dbg_agent_inst.rd(OFF_CLAIM_CLR, v);
    check(v, 32'h0000_0000);
  endtask : test_reset

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    tags(2'h0);
    test_map();
    test_set_clear();
    test_b2b();
    test_race();
    test_reset();
    stop_test();
  end

endmodule : tb
